// File: core/nbc_pkg.sv
/*
  Package for the NAND bus host sequencer: bus timing counts, command codes,
  request kinds, sequencer states and the carrier structs.
  Assumes a 40 MHz system clock; every timing count is derived from it.
*/
package nbc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned NBC_CLK_PS   = 25000;
  localparam int unsigned NBC_T_WP_NS  = 12;
  localparam int unsigned NBC_T_WH_NS  = 10;
  localparam int unsigned NBC_T_WB_NS  = 100;
  localparam int unsigned NBC_T_ADL_NS = 70;
  localparam int unsigned NBC_T_RHW_NS = 60;
  localparam int unsigned NBC_T_REA_NS = 22;
  localparam int unsigned NBC_T_POR_US = 1000;
  // Pin sampler latency: three stages plus the agreement flop
  localparam int unsigned NBC_SYNC_LAT = 4;

  function automatic int unsigned nbc_cyc(input int unsigned ns);
    nbc_cyc = (ns * 1000 + NBC_CLK_PS - 1) / NBC_CLK_PS;
    if (nbc_cyc == 0)
      nbc_cyc = 1;
  endfunction

  localparam int unsigned NBC_WP_CYC  = nbc_cyc(NBC_T_WP_NS);
  localparam int unsigned NBC_WH_CYC  = nbc_cyc(NBC_T_WH_NS);
  localparam int unsigned NBC_WB_CYC  = nbc_cyc(NBC_T_WB_NS);
  localparam int unsigned NBC_ADL_CYC = nbc_cyc(NBC_T_ADL_NS);
  localparam int unsigned NBC_RHW_CYC = nbc_cyc(NBC_T_RHW_NS);
  localparam int unsigned NBC_RE_CYC  = nbc_cyc(NBC_T_REA_NS) + NBC_SYNC_LAT;
  localparam int unsigned NBC_POR_CYC = (NBC_T_POR_US * 1000000) / NBC_CLK_PS;
  localparam int unsigned NBC_CNT_W   = 16;
  localparam int unsigned NBC_FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] NBC_C_READ   = 8'h00;
  localparam logic [7:0] NBC_C_RDO    = 8'h05;
  localparam logic [7:0] NBC_C_PROG   = 8'h80;
  localparam logic [7:0] NBC_C_PROG_L = 8'h81;
  localparam logic [7:0] NBC_C_RDI    = 8'h85;
  localparam logic [7:0] NBC_C_ERASE  = 8'h60;
  localparam logic [7:0] NBC_C_RD_GO  = 8'h30;
  localparam logic [7:0] NBC_C_CACHE  = 8'h31;
  localparam logic [7:0] NBC_C_RDO_GO = 8'hE0;
  localparam logic [7:0] NBC_C_PG_GO  = 8'h10;
  localparam logic [7:0] NBC_C_PG_PL  = 8'h11;
  localparam logic [7:0] NBC_C_PG_CCH = 8'h15;
  localparam logic [7:0] NBC_C_ER_GO  = 8'hD0;
  localparam logic [7:0] NBC_C_ER_PL  = 8'hD1;
  localparam logic [7:0] NBC_C_CEND   = 8'h3F;
  localparam logic [7:0] NBC_C_ID     = 8'h90;
  localparam logic [7:0] NBC_C_PARAM  = 8'hEC;
  localparam logic [7:0] NBC_C_UID    = 8'hED;
  localparam logic [7:0] NBC_C_SETF   = 8'hEF;
  localparam logic [7:0] NBC_C_GETF   = 8'hEE;
  localparam logic [7:0] NBC_C_PROT   = 8'h7A;
  localparam logic [7:0] NBC_C_STAT   = 8'h70;
  localparam logic [7:0] NBC_C_STAT_E = 8'h78;
  localparam logic [7:0] NBC_C_RESET  = 8'hFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {K_CMD, K_ADDR, K_DIN, K_DOUT, K_WAIT} nbc_kind_t;

  typedef enum logic [3:0] {
    ST_POR, ST_IDLE, ST_DATA_WAIT, ST_SETUP, ST_WE_LOW, ST_WE_HIGH,
    ST_RE_LOW, ST_RE_HIGH, ST_WAIT_RDY
  } nbc_fsm_t;

  typedef enum logic [2:0] {SQ_NONE, SQ_RD, SQ_RDO, SQ_PG, SQ_PG2, SQ_ER, SQ_ER2} nbc_seq_t;

  typedef struct packed {
    nbc_kind_t  kind;
    logic [7:0] data;
  } nbc_req_t;

  typedef struct packed {
    logic       ce_b;
    logic       cle;
    logic       ale;
    logic       we_b;
    logic       re_b;
    logic       wp_b;
    logic       io_oe;
    logic [7:0] io;
  } nbc_pins_t;

  typedef struct packed {
    logic     ok;
    nbc_seq_t nxt;
  } nbc_step_t;

endpackage

// File: core/nbc_fifo.sv
/*
  Write-data FIFO with valid/ready on both sides.
  Assumes a single clock; both ready and valid are registered.
*/
`timescale 1ns/1ps
`default_nettype none

module nbc_fifo
  import nbc_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = NBC_FIFO_DEPTH
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
    logic                        in_ready;
    logic                        out_valid;
  } nbc_fifo_st_t;

  nbc_fifo_st_t st;
  nbc_fifo_st_t next_st;
  logic         push;
  logic         pop;

  assign push          = in_valid_in && st.in_ready;
  assign pop           = out_ready_in && st.out_valid;
  assign in_ready_out  = st.in_ready;
  assign out_valid_out = st.out_valid;
  assign out_data_out  = st.mem[st.rd];

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wr] = in_data_in;
      next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (pop)
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    next_st.count     = st.count + (AW + 1)'(push) - (AW + 1)'(pop);
    next_st.in_ready  = (next_st.count < (AW + 1)'(DEPTH));
    next_st.out_valid = (next_st.count != '0);
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      st <= '{mem: '0, wr: '0, rd: '0, count: '0, in_ready: 1'b1, out_valid: 1'b0};
    else
      st <= next_st;
  end

endmodule
`default_nettype wire

// File: core/nbc_host.sv
/*
  NAND bus host sequencer: turns one request at a time (command, address,
  data-in or data-out) into one asynchronous NAND bus cycle; a wait-ready
  request drives no bus cycle and waits on ready/busy.
  Assumes the flash on the far side, a pull-up on ready/busy and a board
  that resolves the data bus from io_oe.
  // Operation
  // - Command cycle: CE low, CLE high, WE strobe
  // - Address cycle: CE low, ALE high, WE strobe
  // - Data in on WE, data out on RE
  // - Read, program, erase, reset command sequences
  // - Two-plane program 80-11-80-10 or 15
  // - Two-plane erase 60-D1-60-D0
  // - Legacy two-plane 80-11-81 and 60-60-D0
  // - After power-up wait ready or 1 ms
  // - Hold write protect low during power-up
*/
`timescale 1ns/1ps
`default_nettype none

module nbc_host
  import nbc_pkg::*;
#(
  parameter int unsigned POR_CYCLES = NBC_POR_CYC
) (
  input  wire logic      clk_sys_in,
  input  wire logic      rst_b_in,
  input  wire logic      wp_req_in,
  input  wire logic      req_valid_in,
  input  wire nbc_req_t  req_in,
  output logic           req_ready_out,
  output logic           done_out,
  output logic           err_out,
  input  wire logic      wdata_valid_in,
  input  wire logic [7:0] wdata_in,
  output logic           wdata_ready_out,
  output logic           rd_valid_out,
  output logic     [7:0] rd_data_out,
  output nbc_pins_t      pins_out,
  input  wire logic [7:0] io_in,
  input  wire logic      rb_b_in
);

  typedef struct packed {
    nbc_fsm_t               fsm;
    nbc_seq_t               seq;
    nbc_kind_t              kind;
    logic [NBC_CNT_W-1:0]   cnt;
    nbc_pins_t              pins;
    logic                   ready;
    logic                   done;
    logic                   err;
    logic                   rd_valid;
    logic [7:0]             rd_data;
    logic [7:0]             io_s1;
    logic [7:0]             io_s2;
    logic [7:0]             io_s3;
    logic [7:0]             io_q;
    logic                   rb_s1;
    logic                   rb_s2;
    logic                   rb_s3;
    logic                   rb_q;
  } nbc_st_t;

  localparam nbc_pins_t PINS_RST = '{ce_b: 1'b1, cle: 1'b0, ale: 1'b0, we_b: 1'b1,
                                     re_b: 1'b1, wp_b: 1'b0, io_oe: 1'b0, io: 8'h00};

  nbc_st_t    st;
  nbc_st_t    next_st;
  logic       fire;
  logic       busy;
  logic       f_valid;
  logic       f_pop;
  logic [7:0] f_data;
  nbc_step_t  step;
  logic       exempt;
  logic       wr_type;

  // ----------------------------------------------------------------
  // Command sequence tracking
  // ----------------------------------------------------------------
  // legal command order
  function automatic nbc_step_t seq_step(input nbc_seq_t s, input logic [7:0] c);
    seq_step = '{ok: 1'b0, nxt: s};
    unique case (c)
      NBC_C_READ:   seq_step = '{ok: (s == SQ_NONE), nxt: SQ_RD};
      NBC_C_RDO:    seq_step = '{ok: (s == SQ_NONE), nxt: SQ_RDO};
      NBC_C_RD_GO:  seq_step = '{ok: (s == SQ_RD), nxt: SQ_NONE};
      NBC_C_CACHE:  seq_step = '{ok: (s == SQ_RD) || (s == SQ_NONE), nxt: SQ_NONE};
      NBC_C_RDO_GO: seq_step = '{ok: (s == SQ_RDO), nxt: SQ_NONE};
      NBC_C_PROG:   seq_step = '{ok: (s == SQ_NONE) || (s == SQ_PG2), nxt: SQ_PG};
      NBC_C_PROG_L: seq_step = '{ok: (s == SQ_PG2), nxt: SQ_PG};
      NBC_C_RDI:    seq_step = '{ok: (s == SQ_PG), nxt: SQ_PG};
      NBC_C_PG_GO:  seq_step = '{ok: (s == SQ_PG), nxt: SQ_NONE};
      NBC_C_PG_CCH: seq_step = '{ok: (s == SQ_PG), nxt: SQ_NONE};
      NBC_C_PG_PL:  seq_step = '{ok: (s == SQ_PG), nxt: SQ_PG2};
      NBC_C_ERASE:  seq_step = '{ok: (s == SQ_NONE) || (s == SQ_ER) || (s == SQ_ER2),
                                 nxt: SQ_ER};
      NBC_C_ER_GO:  seq_step = '{ok: (s == SQ_ER), nxt: SQ_NONE};
      NBC_C_ER_PL:  seq_step = '{ok: (s == SQ_ER), nxt: SQ_ER2};
      NBC_C_PARAM, NBC_C_UID, NBC_C_PROT, NBC_C_CEND, NBC_C_ID, NBC_C_SETF,
      NBC_C_GETF:   seq_step = '{ok: (s == SQ_NONE), nxt: SQ_NONE};
      NBC_C_STAT, NBC_C_STAT_E: seq_step = '{ok: 1'b1, nxt: s};
      NBC_C_RESET:  seq_step = '{ok: 1'b1, nxt: SQ_NONE};
      default:      seq_step = '{ok: 1'b0, nxt: s};
    endcase
  endfunction

  assign fire    = req_valid_in && st.ready;
  assign busy    = !st.rb_q;
  assign step    = seq_step(st.seq, req_in.data);
  assign exempt  = (req_in.data == NBC_C_STAT) || (req_in.data == NBC_C_STAT_E)
                   || (req_in.data == NBC_C_RESET);
  assign wr_type = (req_in.data == NBC_C_PROG) || (req_in.data == NBC_C_PROG_L)
                   || (req_in.data == NBC_C_RDI) || (req_in.data == NBC_C_PG_GO)
                   || (req_in.data == NBC_C_PG_PL) || (req_in.data == NBC_C_PG_CCH)
                   || (req_in.data == NBC_C_ERASE) || (req_in.data == NBC_C_ER_GO)
                   || (req_in.data == NBC_C_ER_PL);

  // Back-pressure: a data-in request stalls until the FIFO has a byte
  nbc_fifo #(
    .WIDTH (8),
    .DEPTH (NBC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (wdata_valid_in),
    .in_ready_out  (wdata_ready_out),
    .in_data_in    (wdata_in),
    .out_valid_out (f_valid),
    .out_ready_in  (f_pop),
    .out_data_out  (f_data)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st          = st;
    f_pop            = 1'b0;
    next_st.done     = 1'b0;
    next_st.err      = 1'b0;
    next_st.rd_valid = 1'b0;
    next_st.io_s1    = io_in;
    next_st.io_s2    = st.io_s1;
    next_st.io_s3    = st.io_s2;
    next_st.rb_s1    = rb_b_in;
    next_st.rb_s2    = st.rb_s1;
    next_st.rb_s3    = st.rb_s2;
    // Glitch filter: take a change only once two late stages agree
    if (st.io_s2 == st.io_s3)
      next_st.io_q = st.io_s3;
    if (st.rb_s2 == st.rb_s3)
      next_st.rb_q = st.rb_s3;
    unique case (st.fsm)
      ST_POR:
      begin
        // no command until ready or timeout
        next_st.cnt = st.cnt + 1'b1;
        if ((st.cnt == NBC_CNT_W'(POR_CYCLES - 1))
            || (st.rb_q && (st.cnt >= NBC_CNT_W'(NBC_WB_CYC))))
        begin
          next_st.fsm       = ST_IDLE;
          next_st.ready     = 1'b1;
          next_st.pins.wp_b = !wp_req_in;
        end
      end
      ST_IDLE:
      begin
        next_st.pins.wp_b = !wp_req_in;
        if (fire)
        begin
          next_st.ready = 1'b0;
          next_st.kind  = req_in.kind;
          next_st.cnt   = '0;
          unique case (req_in.kind)
            K_CMD:
            begin
              if (!step.ok || (busy && !exempt) || (wr_type && wp_req_in))
              begin
                next_st.err   = 1'b1;
                next_st.done  = 1'b1;
                next_st.ready = 1'b1;
              end
              else
              begin
                next_st.seq        = step.nxt;
                next_st.fsm        = ST_SETUP;
                next_st.pins.ce_b  = 1'b0;
                next_st.pins.cle   = 1'b1;
                next_st.pins.io    = req_in.data;
                next_st.pins.io_oe = 1'b1;
              end
            end
            K_ADDR:
            begin
              if (busy)
              begin
                next_st.err   = 1'b1;
                next_st.done  = 1'b1;
                next_st.ready = 1'b1;
              end
              else
              begin
                next_st.fsm        = ST_SETUP;
                next_st.pins.ce_b  = 1'b0;
                next_st.pins.ale   = 1'b1;
                next_st.pins.io    = req_in.data;
                next_st.pins.io_oe = 1'b1;
              end
            end
            K_DIN:
            begin
              if (busy || wp_req_in)
              begin
                next_st.err   = 1'b1;
                next_st.done  = 1'b1;
                next_st.ready = 1'b1;
              end
              else
              begin
                next_st.fsm       = ST_DATA_WAIT;
                next_st.pins.ce_b = 1'b0;
              end
            end
            K_DOUT:
            begin
              if (busy)
              begin
                next_st.err   = 1'b1;
                next_st.done  = 1'b1;
                next_st.ready = 1'b1;
              end
              else
              begin
                // device drives the bus while RE is low
                next_st.fsm       = ST_RE_LOW;
                next_st.pins.ce_b = 1'b0;
                next_st.pins.re_b = 1'b0;
              end
            end
            K_WAIT:
              next_st.fsm = ST_WAIT_RDY;
            default:
            begin
              next_st.err   = 1'b1;
              next_st.done  = 1'b1;
              next_st.ready = 1'b1;
            end
          endcase
        end
      end
      ST_DATA_WAIT:
      begin
        if (f_valid)
        begin
          f_pop              = 1'b1;
          next_st.pins.io    = f_data;
          next_st.pins.io_oe = 1'b1;
          next_st.fsm        = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        next_st.pins.we_b = 1'b0;
        next_st.fsm       = ST_WE_LOW;
      end
      ST_WE_LOW:
      begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == NBC_CNT_W'(NBC_WP_CYC - 1))
        begin
          next_st.pins.we_b = 1'b1;
          next_st.cnt       = '0;
          next_st.fsm       = ST_WE_HIGH;
        end
      end
      ST_WE_HIGH:
      begin
        next_st.cnt = st.cnt + 1'b1;
        // Commands wait out WE-to-busy, addresses the address-to-data gap
        if (((st.kind == K_CMD) && (st.cnt == NBC_CNT_W'(NBC_WB_CYC - 1)))
            || ((st.kind == K_ADDR) && (st.cnt == NBC_CNT_W'(NBC_ADL_CYC - 1)))
            || ((st.kind == K_DIN) && (st.cnt == NBC_CNT_W'(NBC_WH_CYC - 1))))
        begin
          next_st.pins.ce_b  = 1'b1;
          next_st.pins.cle   = 1'b0;
          next_st.pins.ale   = 1'b0;
          next_st.pins.io_oe = 1'b0;
          next_st.done       = 1'b1;
          next_st.ready      = 1'b1;
          next_st.fsm        = ST_IDLE;
        end
      end
      ST_RE_LOW:
      begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == NBC_CNT_W'(NBC_RE_CYC - 1))
        begin
          next_st.pins.re_b = 1'b1;
          next_st.rd_data   = st.io_q;
          next_st.rd_valid  = 1'b1;
          next_st.cnt       = '0;
          next_st.fsm       = ST_RE_HIGH;
        end
      end
      ST_RE_HIGH:
      begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == NBC_CNT_W'(NBC_RHW_CYC - 1))
        begin
          next_st.pins.ce_b = 1'b1;
          next_st.done      = 1'b1;
          next_st.ready     = 1'b1;
          next_st.fsm       = ST_IDLE;
        end
      end
      ST_WAIT_RDY:
      begin
        // done once ready/busy is high after tWB
        if (st.cnt < NBC_CNT_W'(NBC_WB_CYC))
          next_st.cnt = st.cnt + 1'b1;
        else if (st.rb_q)
        begin
          next_st.done  = 1'b1;
          next_st.ready = 1'b1;
          next_st.fsm   = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      st <= '{fsm: ST_POR, seq: SQ_NONE, kind: K_WAIT, cnt: '0, pins: PINS_RST,
              ready: 1'b0, done: 1'b0, err: 1'b0, rd_valid: 1'b0, rd_data: 8'h00,
              io_s1: 8'h00, io_s2: 8'h00, io_s3: 8'h00, io_q: 8'h00,
              rb_s1: 1'b0, rb_s2: 1'b0, rb_s3: 1'b0, rb_q: 1'b0};
    else
      st <= next_st;
  end

  assign req_ready_out = st.ready;
  assign done_out      = st.done;
  assign err_out       = st.err;
  assign rd_valid_out  = st.rd_valid;
  assign rd_data_out   = st.rd_data;
  assign pins_out      = st.pins;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_cmd_strobe: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $fell(st.pins.we_b) && st.pins.cle |-> !st.pins.ale && !st.pins.ce_b && st.pins.re_b)
    else $error("command strobe with wrong control levels");

  a_addr_strobe: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $fell(st.pins.we_b) && st.pins.ale |-> !st.pins.cle && !st.pins.ce_b && st.pins.io_oe)
    else $error("address strobe with wrong control levels");

  a_read_levels: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $fell(st.pins.re_b) |-> st.pins.we_b && !st.pins.io_oe && !st.pins.ce_b
      ##(NBC_RE_CYC) st.rd_valid)
    else $error("read strobe not followed by captured byte");

  a_undef_refused: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    fire && (req_in.kind == K_CMD) && !step.ok |=> st.err && st.done && st.pins.we_b)
    else $error("undefined or out-of-order command not refused");

  a_busy_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    fire && (req_in.kind == K_CMD) && busy && !exempt |=> st.err ##1 st.pins.we_b)
    else $error("command issued while busy");

  a_por_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (st.fsm == ST_POR) |-> st.pins.ce_b && !st.pins.wp_b && !st.ready)
    else $error("bus active during power-up wait");

  a_wp_inhibit: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $fell(st.pins.we_b) && st.pins.cle && (st.pins.io == NBC_C_PROG) |-> st.pins.wp_b)
    else $error("program issued under write protect");

  a_idle_float: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (st.fsm == ST_IDLE) |-> st.pins.ce_b && !st.pins.io_oe && st.pins.we_b && st.pins.re_b)
    else $error("bus not released when idle");

  a_wait_ready: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (st.fsm == ST_WAIT_RDY) && busy |=> !st.done)
    else $error("wait completed while device busy");

endmodule
`default_nettype wire

// File: verif/nbc_flash_model.sv
/* Behavioural flash device for the host bench.
   Assumes the host's registered pin struct and a pulled-up ready/busy. */
`timescale 1ns/1ps
`default_nettype none
module nbc_flash_model
  import nbc_pkg::*;
(
  input  wire logic      clk_sys_in,
  input  wire nbc_pins_t pins_in,
  output logic [7:0]     io_out,
  output logic           rb_b_out,
  output logic [7:0]     cmd_out,
  output logic [7:0]     addr_out,
  output logic [7:0]     din_out
);
  int   busy = 40;
  logic we_q = 1'b1;
  // One process owns busy: a confirm on the same edge as the count wins
  // power-up busy
  // latch on WE rise, seen one clock later
  always @(posedge clk_sys_in)
  begin
    we_q <= pins_in.we_b;
    if (busy > 0)
      busy <= busy - 1;
    if (pins_in.we_b && !we_q && !pins_in.ce_b)
    begin
      if (pins_in.cle)
      begin
        cmd_out <= pins_in.io;
        if (pins_in.wp_b && (pins_in.io inside {8'h30, 8'h10, 8'hD0}))
          busy <= 30;
      end
      else if (pins_in.ale)
        addr_out <= pins_in.io;
      else if (pins_in.wp_b)
        din_out <= pins_in.io;
    end
  end
  assign rb_b_out = (busy == 0);
  assign io_out = (!pins_in.ce_b && !pins_in.re_b) ? 8'hC3 : 8'h3C;
endmodule
`default_nettype wire

// File: verif/nbc_host_test.sv
/* Self-checking bench for the host sequencer.
   Assumes the flash model on the pins and a short power-up count. */
`timescale 1ns/1ps
`default_nettype none
module nbc_host_test;
  import nbc_pkg::*;
  logic       clk_sys_in = 0, rst_b_in = 0, wp = 0, vld = 0, wv = 0;
  nbc_req_t   rq = '0;
  logic [7:0] wd = '0, io, cmd, adr, din, rdd, b;
  logic       rdy, done, err, wr, rv, rb, e;
  nbc_pins_t  pins;
  int         bad_count = 0, n_checks = 0, cyc = 0, rv_seen = 0;
  nbc_host #(.POR_CYCLES(200)) i_dut (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .wp_req_in(wp), .req_valid_in(vld), .req_in(rq),
    .req_ready_out(rdy), .done_out(done), .err_out(err),
    .wdata_valid_in(wv), .wdata_in(wd), .wdata_ready_out(wr),
    .rd_valid_out(rv), .rd_data_out(rdd), .pins_out(pins), .io_in(io),
    .rb_b_in(rb));
  nbc_flash_model i_flash (.clk_sys_in(clk_sys_in), .pins_in(pins),
    .io_out(io), .rb_b_out(rb), .cmd_out(cmd), .addr_out(adr),
    .din_out(din));
  initial
    forever #12.5 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s exp %h got %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic req(nbc_kind_t k, logic [7:0] d);
    @(posedge clk_sys_in);
    vld <= 1;
    rq <= '{k, d};
    do @(negedge clk_sys_in); while (rdy !== 1'b1);
    @(posedge clk_sys_in);
    vld <= 0;
    do @(negedge clk_sys_in); while (done !== 1'b1);
    e = err;
    b = rdd;
  endtask
  task automatic ok(nbc_kind_t k, logic [7:0] d);
    req(k, d);
    chk("err", 8'h00, {7'h0, e});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_codes;
    logic [7:0] c [8] = '{8'hEC, 8'hED, 8'h7A, 8'h90, 8'hEF, 8'hEE, 8'h3F, 8'h31};
    ok(K_CMD, 8'h70);
    chk("cmd", 8'h70, cmd);
    req(K_CMD, 8'h01);
    chk("undef", 8'h01, {7'h0, e});
    chk("cmd", 8'h70, cmd);
    foreach (c[i])
    begin
      ok(K_CMD, c[i]);
      chk("cmd", c[i], cmd);
    end
  endtask
  task automatic t_read;
    ok(K_CMD, 8'h00);
    ok(K_ADDR, 8'h12);
    chk("addr", 8'h12, adr);
    ok(K_CMD, 8'h30);
    ok(K_CMD, 8'h70);
    chk("rb", 8'h00, {7'h0, rb});
    req(K_CMD, 8'h00);
    chk("busy", 8'h01, {7'h0, e});
    ok(K_WAIT, 8'h00);
    chk("rb", 8'h01, {7'h0, rb});
    ok(K_DOUT, 8'h00);
    chk("dout", 8'hC3, b);
    chk("rd_valid", 8'h01, 8'(rv_seen));
  endtask
  task automatic t_prog;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys_in);
      wv <= 1;
      wd <= 8'h90 + 8'(i);
      do @(negedge clk_sys_in); while (wr !== 1'b1);
    end
    @(posedge clk_sys_in);
    wv <= 0;
    @(negedge clk_sys_in);
    chk("full", 8'h00, {7'h0, wr});
    ok(K_CMD, 8'h80);
    ok(K_ADDR, 8'h05);
    repeat (8) ok(K_DIN, 8'h00);
    chk("din", 8'h97, din);
    ok(K_CMD, 8'h10);
    ok(K_WAIT, 8'h00);
  endtask
  task automatic t_plane;
    nbc_req_t s [14] = '{'{K_CMD, 8'h80}, '{K_ADDR, 8'h01}, '{K_CMD, 8'h11},
      '{K_CMD, 8'h81}, '{K_ADDR, 8'h02}, '{K_CMD, 8'h15}, '{K_CMD, 8'h60},
      '{K_ADDR, 8'h03}, '{K_CMD, 8'hD1}, '{K_CMD, 8'h60}, '{K_ADDR, 8'h04},
      '{K_CMD, 8'hD0}, '{K_CMD, 8'hFF}, '{K_WAIT, 8'h00}};
    foreach (s[i])
      ok(s[i].kind, s[i].data);
    @(posedge clk_sys_in);
    wp <= 1;
    req(K_CMD, 8'h60);
    chk("wp", 8'h01, {7'h0, e});
    chk("wp_pin", 8'h00, {7'h0, pins.wp_b});
    @(posedge clk_sys_in);
    wp <= 0;
  endtask
  // Counts read strobes seen by the bench
  always @(posedge clk_sys_in)
    if (rv === 1'b1)
      rv_seen++;
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    rst_b_in <= 1;
    repeat (2) @(negedge clk_sys_in);
    // write protect held low through power-up
    chk("por_wp", 8'h00, {7'h0, pins.wp_b});
    chk("por_rdy", 8'h00, {7'h0, rdy});
    t_codes;
    t_read;
    t_prog;
    t_plane;
    close_out;
  end
endmodule
`default_nettype wire
